/* File: twc_slave.sv */
`timescale 1ns/10ps
`include "twc_defs.svh"

// What this block does
// - write address with direction low is acknowledged when it matches
// - two data bytes after write address load the word, each acknowledged
// - read address with direction high is acknowledged, then upper byte sent
// - after master acknowledges upper byte, lower byte is sent
// - master not-acknowledge, start or stop ends read; data line released
// - words travel most significant byte first in both directions
// - master code 00001xxx is not acknowledged but selects high-speed filtering
// - repeated start after master code continues normal protocol at high speed
// - a stop ends high-speed mode and restores normal filtering
// - slave address 10000xx taken from address select pin at every start
// - general call followed by command 06h loads CFG_RST (reset itself loads TWC_CFG_RST)
// - a stalled transfer is abandoned after 28 ms
module twc_slave
  import twc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `TWC_TIMEOUT_CYC,
  parameter logic [15:0] CFG_RST     = `TWC_CFG_RST
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        NRST,
  // two-wire bus pins
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE,
  // address select pin state
  input  wire logic [1:0]  ADDR_SEL,
  // configuration word and mode
  output logic [15:0]      CFG_WORD,
  output logic             HS_MODE
);

  localparam int unsigned TO_W = $clog2(TIMEOUT_CYC + 1);

  logic             scl_f, sda_f, scl_p_q, sda_p_q;
  logic             scl_rise, scl_fall, start, stop;
  logic             timeout, quiet;
  logic [1:0]       asel1_q, asel2_q;
  twc_state_t       st_q, st_d;
  logic [3:0]       cnt_q, cnt_d;
  logic [7:0]       sh_q, sh_d;
  logic [6:0]       own_q, own_d;
  logic             dir_q, dir_d;
  logic             gc_q, gc_d;
  logic             bidx_q, bidx_d;
  logic [7:0]       hi_q, hi_d;
  logic [15:0]      cfg_q, cfg_d;
  logic             hs_q, hs_d;
  logic             oe_q, oe_d;
  logic             sda_out_q;
  logic [TO_W-1:0]  to_q, to_d;
  logic [7:0]       tx_byte, nxt_byte;

  twc_pin_filter u_scl_filt (
    .clk   (CLK),
    .nrst  (NRST),
    .pin   (SCL_IN),
    .hs    (hs_q),
    .level (scl_f)
  );
  twc_pin_filter u_sda_filt (
    .clk   (CLK),
    .nrst  (NRST),
    .pin   (SDA_IN),
    .hs    (hs_q),
    .level (sda_f)
  );
  assign scl_rise = scl_f & ~scl_p_q;
  assign scl_fall = ~scl_f & scl_p_q;
  assign start    = scl_f & scl_p_q & sda_p_q & ~sda_f;
  assign stop     = scl_f & scl_p_q & ~sda_p_q & sda_f;
  assign timeout  = (st_q != ST_IDLE) && (to_q == TO_W'(TIMEOUT_CYC - 1));
  assign quiet    = ~start & ~stop & ~timeout;
  assign tx_byte  = cfg_q[15:8];
  assign nxt_byte = bidx_q ? cfg_q[15:8] : cfg_q[7:0];
  assign SDA_OUT  = sda_out_q;
  assign SDA_OE   = oe_q;
  assign CFG_WORD = cfg_q;
  assign HS_MODE  = hs_q;

  // any clock edge or start condition restarts the stall timer
  always_comb begin
    to_d = to_q + TO_W'(1);
    if (st_q == ST_IDLE || scl_rise || scl_fall || start || timeout) begin
      to_d = '0;
    end
  end

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    own_d  = own_q;
    dir_d  = dir_q;
    gc_d   = gc_q;
    bidx_d = bidx_q;
    hi_d   = hi_q;
    cfg_d  = cfg_q;
    hs_d   = hs_q;
    oe_d   = oe_q;
    if (stop) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
      hs_d = 1'b0;
    end else if (start) begin
      // repeated start keeps high-speed mode
      st_d  = ST_ADDR;
      cnt_d = 4'h0;
      oe_d  = 1'b0;
      own_d = {`TWC_ADDR_BASE, asel2_q};
    end else if (timeout) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE, ST_SKIP: begin
        end
        ST_ADDR, ST_WBYTE, ST_GCMD: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_f};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            st_d = ST_SKIP;
            if (st_q == ST_ADDR) begin
              bidx_d = 1'b0;
              if (sh_q[7:1] == own_q) begin
                oe_d  = 1'b1;
                dir_d = sh_q[0];
                gc_d  = 1'b0;
                st_d  = ST_AACK;
              end else if (sh_q == {`TWC_GC_ADDR, 1'b0}) begin
                oe_d  = 1'b1;
                dir_d = 1'b0;
                gc_d  = 1'b1;
                st_d  = ST_AACK;
              end else if (sh_q[7:3] == `TWC_HS_CODE) begin
                hs_d = 1'b1;
              end
            end else if (st_q == ST_WBYTE) begin
              oe_d = 1'b1;
              st_d = ST_WACK;
            end else if (sh_q == `TWC_GC_RESET) begin
              oe_d = 1'b1;
              st_d = ST_GACK;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            cnt_d = 4'h0;
            oe_d  = 1'b0;
            if (gc_q) begin
              st_d = ST_GCMD;
            end else if (dir_q) begin
              oe_d  = ~tx_byte[7];
              sh_d  = {tx_byte[6:0], 1'b0};
              cnt_d = 4'h1;
              st_d  = ST_TX;
            end else begin
              st_d = ST_WBYTE;
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            oe_d  = 1'b0;
            cnt_d = 4'h0;
            if (!bidx_q) begin
              hi_d   = sh_q;
              bidx_d = 1'b1;
              st_d   = ST_WBYTE;
            end else begin
              // a third byte is not acknowledged
              cfg_d = {hi_q, sh_q};
              st_d  = ST_SKIP;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_q == 4'h8) begin
              oe_d = 1'b0;
              st_d = ST_MACK;
            end else begin
              oe_d  = ~sh_q[7];
              sh_d  = {sh_q[6:0], 1'b0};
              cnt_d = cnt_q + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise && sda_f) begin
            st_d = ST_SKIP;
          end else if (scl_fall) begin
            // after the lower byte the upper byte follows again
            oe_d   = ~nxt_byte[7];
            sh_d   = {nxt_byte[6:0], 1'b0};
            cnt_d  = 4'h1;
            bidx_d = ~bidx_q;
            st_d   = ST_TX;
          end
        end
        ST_GACK: begin
          if (scl_fall) begin
            oe_d  = 1'b0;
            cfg_d = CFG_RST;
            st_d  = ST_SKIP;
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      scl_p_q   <= 1'b1;
      sda_p_q   <= 1'b1;
      asel1_q   <= 2'h0;
      asel2_q   <= 2'h0;
      st_q      <= ST_IDLE;
      cnt_q     <= 4'h0;
      sh_q      <= 8'h00;
      own_q     <= 7'h00;
      dir_q     <= 1'b0;
      gc_q      <= 1'b0;
      bidx_q    <= 1'b0;
      hi_q      <= 8'h00;
      cfg_q     <= `TWC_CFG_RST;
      hs_q      <= 1'b0;
      oe_q      <= 1'b0;
      sda_out_q <= 1'b0;
      to_q      <= '0;
    end else begin
      scl_p_q   <= scl_f;
      sda_p_q   <= sda_f;
      asel1_q   <= ADDR_SEL;
      asel2_q   <= asel1_q;
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      sh_q      <= sh_d;
      own_q     <= own_d;
      dir_q     <= dir_d;
      gc_q      <= gc_d;
      bidx_q    <= bidx_d;
      hi_q      <= hi_d;
      cfg_q     <= cfg_d;
      hs_q      <= hs_d;
      oe_q      <= oe_d;
      sda_out_q <= 1'b0;
      to_q      <= to_d;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  AST_STOP_HS: assert property (stop |=> !hs_q && !oe_q)
    else $error("stop did not end high-speed mode");
  AST_HS_NOACK: assert property (quiet && st_q == ST_ADDR && scl_fall &&
      cnt_q == 4'h8 && sh_q[7:3] == `TWC_HS_CODE |=> hs_q && !oe_q)
    else $error("master code handled wrongly");
  AST_ADDR_ACK: assert property (quiet && st_q == ST_ADDR && scl_fall &&
      cnt_q == 4'h8 && sh_q[7:1] == own_q |=> oe_q && st_q == ST_AACK)
    else $error("own address not acknowledged");
  AST_MISMATCH: assert property (quiet && st_q == ST_ADDR && scl_fall &&
      cnt_q == 4'h8 && sh_q[7:1] != own_q && sh_q != 8'h00
      |=> !oe_q && st_q == ST_SKIP)
    else $error("foreign address acknowledged");
  AST_WORD_LOAD: assert property (cfg_q != $past(cfg_q) |->
      $past(st_q) == ST_WACK && $past(bidx_q) ||
      $past(st_q) == ST_GACK)
    else $error("word changed outside a write");
  AST_MSB_FIRST: assert property (quiet && st_q == ST_AACK && dir_q &&
      !gc_q && scl_fall |=> oe_q == ~cfg_q[15] && st_q == ST_TX)
    else $error("upper bit not sent first");
  AST_NACK_END: assert property (quiet && st_q == ST_MACK && scl_rise &&
      sda_f |=> st_q == ST_SKIP ##1 !oe_q)
    else $error("read continued after not-acknowledge");
  AST_TIMEOUT: assert property (timeout && !start && !stop
      |=> st_q == ST_IDLE && !oe_q)
    else $error("stalled transfer not abandoned");
  AST_ADDR_SAMPLE: assert property (start && !stop
      |=> own_q == {`TWC_ADDR_BASE, $past(asel2_q)})
    else $error("address not taken at start");
  AST_GC_RESET: assert property (quiet && st_q == ST_GACK && scl_fall
      |=> cfg_q == CFG_RST)
    else $error("reset command did not restore word");

endmodule

/* File: twc_defs.svh */
`ifndef TWC_DEFS_SVH
`define TWC_DEFS_SVH

// clock rate and derived timing
`define TWC_CLK_MHZ       250
`define TWC_TIMEOUT_MS    28
`define TWC_TIMEOUT_CYC   (`TWC_TIMEOUT_MS * 1000 * `TWC_CLK_MHZ)
`define TWC_FILT_FS_NS    50
`define TWC_FILT_HS_NS    10
`define TWC_FILT_FS_CYC   ((`TWC_FILT_FS_NS * `TWC_CLK_MHZ + 999) / 1000)
`define TWC_FILT_HS_CYC   ((`TWC_FILT_HS_NS * `TWC_CLK_MHZ + 999) / 1000)

// address and command codes
`define TWC_ADDR_BASE     5'h10
`define TWC_GC_ADDR       7'h00
`define TWC_GC_RESET      8'h06
`define TWC_HS_CODE       5'h01

// reset value of the configuration word
`define TWC_CFG_RST       16'h0000

`endif

/* File: twc_pkg.sv */
package twc_pkg;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_ADDR  = 4'h1,
    ST_AACK  = 4'h2,
    ST_WBYTE = 4'h3,
    ST_WACK  = 4'h4,
    ST_TX    = 4'h5,
    ST_MACK  = 4'h6,
    ST_GCMD  = 4'h7,
    ST_GACK  = 4'h8,
    ST_SKIP  = 4'h9
  } twc_state_t;

endpackage

/* File: twc_pin_filter.sv */
`timescale 1ns/10ps
`include "twc_defs.svh"

// two-flop synchroniser followed by a spike filter whose length
// follows the bus speed mode
module twc_pin_filter #(
  parameter int unsigned CNT_W  = 4,
  parameter int unsigned FS_CYC = `TWC_FILT_FS_CYC,
  parameter int unsigned HS_CYC = `TWC_FILT_HS_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // pin and mode
  input  wire logic pin,
  input  wire logic hs,
  // filtered level
  output logic      level
);

  logic             sync1_q;
  logic             sync2_q;
  logic             lvl_q;
  logic             lvl_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] lim;

  assign lim   = hs ? CNT_W'(HS_CYC) : CNT_W'(FS_CYC);
  assign level = lvl_q;

  always_comb begin
    lvl_d = lvl_q;
    cnt_d = '0;
    if (sync2_q != lvl_q) begin
      if (cnt_q + CNT_W'(1) >= lim) begin
        lvl_d = sync2_q;
      end else begin
        cnt_d = cnt_q + CNT_W'(1);
      end
    end
  end

  // idle bus is high, so the synchroniser and level flops reset high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      lvl_q   <= 1'b1;
      cnt_q   <= '0;
    end else begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
      lvl_q   <= lvl_d;
      cnt_q   <= cnt_d;
    end
  end

endmodule

/* File: twc_master.sv */
`timescale 1ns/10ps

// open-drain bus master on its own link clock; it only ever pulls a
// line low or lets the pull-up take it, so released lines read high
module twc_master (
  // link clock
  input  wire logic lclk,
  // resolved data wire
  input  wire logic sda,
  // pull-down enables
  output logic      scl_pull,
  output logic      sda_pull
);
  // low 2q, high q: q=70 gives ~397 kHz, q=9 gives ~3.1 MHz
  int unsigned q = 70;

  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end

  task automatic tick(input int unsigned n);
    repeat (n) @(posedge lclk);
  endtask

  task automatic set_hs(input logic on);
    q = on ? 9 : 70;
  endtask

  // also serves as repeated start, keeping the bus speed that set_hs chose
  task automatic start();
    @(posedge lclk);
    sda_pull <= 1'b0;
    tick(q);
    scl_pull <= 1'b0;
    tick(q);
    sda_pull <= 1'b1;
    tick(q);
    scl_pull <= 1'b1;
  endtask

  task automatic stop();
    @(posedge lclk);
    sda_pull <= 1'b1;
    tick(q);
    scl_pull <= 1'b0;
    tick(q);
    sda_pull <= 1'b0;
    tick(q);
  endtask

  // two ticks after the fall keep the data hold time
  task automatic clk_bit(input logic drv, output logic smp);
    tick(2);
    sda_pull <= drv;
    tick(2 * q - 2);
    scl_pull <= 1'b0;
    tick(q / 2);
    smp = sda;
    tick(q - q / 2);
    scl_pull <= 1'b1;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(~b[i], s);
    end
    clk_bit(1'b0, s);
    ack = ~s;
  endtask

  task automatic recv_byte(output logic [7:0] b, input logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b0, s);
      b[i] = s;
    end
    clk_bit(ack, s);
  endtask
endmodule

/* File: twc_tb.sv */
`timescale 1ns/10ps

`define TWC_CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
    end \
  end

module testbench;
  logic        clk;
  logic        lclk;
  logic        nrst;
  logic [1:0]  addr_sel;
  logic        scl;
  logic        sda;
  logic        sda_out;
  logic        sda_oe;
  logic [15:0] cfg_word;
  logic        hs_mode;
  logic        m_scl;
  logic        m_sda;
  logic        ack;
  logic [7:0]  rb;
  int          fails = 0;
  int          checked = 0;

  assign scl = ~m_scl;
  assign sda = ~(m_sda | (sda_oe & ~sda_out));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // link clock phase offset so its edges never line up with clk
  initial begin
    lclk = 1'b0;
    #3.7;
    forever #6 lclk = ~lclk;
  end

  twc_slave #(.TIMEOUT_CYC(2000)) dut (
    .CLK(clk), .NRST(nrst), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDR_SEL(addr_sel),
    .CFG_WORD(cfg_word), .HS_MODE(hs_mode)
  );

  twc_master m (
    .lclk(lclk), .sda(sda), .scl_pull(m_scl), .sda_pull(m_sda)
  );

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic set_sel(input logic [1:0] s);
    @(negedge clk);
    addr_sel = s;
    wait_clk(4);
  endtask

  task automatic tally_and_finish();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic t_reset();
    `TWC_CHK(cfg_word, 16'h0000)
    `TWC_CHK(hs_mode, 1'b0)
    `TWC_CHK(sda_oe, 1'b0)
    `TWC_CHK(sda_out, 1'b0)
  endtask

  // third data byte must be refused and leave the word alone
  task automatic t_write();
    set_sel(2'h2);
    m.start();
    m.send_byte(8'h84, ack);
    `TWC_CHK(ack, 1'b1)
    m.send_byte(8'h5a, ack);
    `TWC_CHK(ack, 1'b1)
    m.send_byte(8'hc3, ack);
    `TWC_CHK(ack, 1'b1)
    m.send_byte(8'hff, ack);
    `TWC_CHK(ack, 1'b0)
    m.stop();
    wait_clk(4);
    `TWC_CHK(cfg_word, 16'h5ac3)
  endtask

  // a wrap after the nack would pull the line for bit 7 of 8'h5a
  task automatic t_read();
    m.start();
    m.send_byte(8'h85, ack);
    `TWC_CHK(ack, 1'b1)
    m.recv_byte(rb, 1'b1);
    `TWC_CHK(rb, 8'h5a)
    m.recv_byte(rb, 1'b0);
    `TWC_CHK(rb, 8'hc3)
    wait_clk(40);
    `TWC_CHK(sda_oe, 1'b0)
    m.stop();
  endtask

  task automatic t_timeout();
    m.start();
    m.send_byte(8'h85, ack);
    `TWC_CHK(ack, 1'b1)
    wait_clk(40);
    `TWC_CHK(sda_oe, 1'b1)
    `TWC_CHK(sda_out, 1'b0)
    wait_clk(2100);
    `TWC_CHK(sda_oe, 1'b0)
    m.stop();
  endtask

  task automatic t_gcall();
    m.start();
    m.send_byte(8'h00, ack);
    `TWC_CHK(ack, 1'b1)
    m.send_byte(8'h06, ack);
    `TWC_CHK(ack, 1'b1)
    m.stop();
    wait_clk(4);
    `TWC_CHK(cfg_word, 16'h0000)
  endtask

  task automatic t_hs();
    logic [1:0] sv [3] = '{2'h0, 2'h1, 2'h3};
    m.start();
    m.send_byte(8'h09, ack);
    `TWC_CHK(ack, 1'b0)
    wait_clk(20);
    `TWC_CHK(hs_mode, 1'b1)
    m.set_hs(1'b1);
    foreach (sv[i]) begin
      set_sel(sv[i]);
      m.start();
      m.send_byte(8'h80 | {5'h00, sv[i], 1'b0}, ack);
      `TWC_CHK(ack, 1'b1)
    end
    set_sel(2'h0);
    m.start();
    m.send_byte(8'h84, ack);
    `TWC_CHK(ack, 1'b0)
    m.send_byte(8'h11, ack);
    `TWC_CHK(ack, 1'b0)
    m.start();
    m.send_byte(8'h00, ack);
    `TWC_CHK(ack, 1'b1)
    // only the reset command is taken after a general call
    m.send_byte(8'h81, ack);
    `TWC_CHK(ack, 1'b0)
    `TWC_CHK(cfg_word, 16'h0000)
    m.start();
    m.send_byte(8'h80, ack);
    m.send_byte(8'h12, ack);
    m.send_byte(8'h34, ack);
    `TWC_CHK(ack, 1'b1)
    `TWC_CHK(hs_mode, 1'b1)
    m.start();
    m.send_byte(8'h81, ack);
    m.recv_byte(rb, 1'b1);
    `TWC_CHK(rb, 8'h12)
    m.recv_byte(rb, 1'b1);
    `TWC_CHK(rb, 8'h34)
    // a further acknowledge wraps back to the upper byte
    m.recv_byte(rb, 1'b0);
    `TWC_CHK(rb, 8'h12)
    m.stop();
    wait_clk(5);
    `TWC_CHK(hs_mode, 1'b0)
    `TWC_CHK(cfg_word, 16'h1234)
    m.set_hs(1'b0);
  endtask

  initial begin
    // traffic needs about 330 us; this keeps the run under 100k cycles
    #380000;
    fails++;
    tally_and_finish();
  end

  initial begin
    nrst = 1'b0;
    addr_sel = 2'h0;
    wait_clk(3);
    nrst = 1'b1;
    wait_clk(4);
    t_reset();
    t_write();
    t_read();
    t_timeout();
    t_gcall();
    t_hs();
    tally_and_finish();
  end
endmodule
